//--- logic/anarb_top.sv
// negotiation arbiter with register slave
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - negotiate only when both ends negotiate; otherwise use parallel detection
// - transmitted burst ability content comes from the advertisement register
// - send fast link pulse bursts carrying the link control word
// - store received partner ability word in partner ability register
// - pick best common: 100 full, (T4 never), 100 half, 10 full, 10 half
// - completion sets complete flag in basic and consolidated status
// - after completion enable resolved technology, power down the others
// - no burst reply: parallel detect and clear partner capable flag
// - parallel detect sets partner ability bit 5 or bit 7
// - parallel detect also sets complete and enables detected technology
// - only normal link pulses: select 10 megabit without management
// - scrambled idles: select non-negotiating 100 megabit partner
// - burst reply sets partner capable flag
// - no receive signal sets the no-signal status bit
// - several indications at once set parallel detection fault
// - partner remote fault sets remote fault bits in four registers
// - local link fault sets remote fault bit of advertised word
// - restart on link failure, restart write, or enable toggle
// - any reset returns arbiter and progress monitor to idle
module anarb_top #(
  parameter int FLP_SLOT_CYC_P = anarb_pkg::FLP_SLOT_CYC,
  parameter int FLP_BURST_CYC_P = anarb_pkg::FLP_BURST_CYC,
  parameter int NOSIG_CYC_P = anarb_pkg::NOSIG_BURSTS * anarb_pkg::FLP_BURST_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [anarb_pkg::AXI_AW-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [anarb_pkg::AXI_DW-1:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [anarb_pkg::AXI_AW-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [anarb_pkg::AXI_DW-1:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic I_RX_FLP_VALID,
  input wire logic [anarb_pkg::REG_W-1:0] I_RX_FLP_WORD,
  input wire logic I_RX_NLP,
  input wire logic I_RX_IDLE100,
  input wire logic I_LINK_FAIL,
  input wire logic I_LOCAL_FAULT,
  input wire logic I_HW_MODE,
  input wire logic I_NEG_SELECT,
  output logic O_TX_FLP,
  output logic O_EN_100TX,
  output logic O_EN_10T,
  output logic O_FULL_DUPLEX,
  output logic O_NEG_COMPLETE
);
  import anarb_pkg::*;

  localparam logic [CNT_W-1:0] NOSIG_LIM = CNT_W'(NOSIG_CYC_P - 1);

  typedef struct packed {
    anarb_state_t fsm;
    logic ctrl_en;
    logic [REG_W-1:0] adv;
    logic [REG_W-1:0] lpa;
    logic lp_cap;
    logic pd_fault;
    logic rfault;
    logic cmpl;
    logic nosig;
    logic [2:0] prog;
    logic [CNT_W-1:0] nosig_cnt;
    logic en100;
    logic en10;
    logic fdx;
    logic [AXI_AW-1:0] awaddr;
    logic aw_full;
    logic [REG_W-1:0] wdata;
    logic [1:0] wstrb;
    logic w_full;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DW-1:0] rdata;
  } anarb_top_st_t;

  anarb_top_st_t st_reg;
  anarb_top_st_t st_next;

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [IDX_W-1:0] reg_idx(input logic [AXI_AW-1:0] a);
    reg_idx = a[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    logic [IDX_W-1:0] i;
    i = reg_idx(a);
    mapped = (i == IDX_CTRL) || (i == IDX_STAT) || (i == IDX_ADV) || (i == IDX_LPA)
      || (i == IDX_EXP) || (i == IDX_QSTAT) || (i == IDX_XSTAT);
  endfunction

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                               input logic [REG_W-1:0] d,
                                               input logic [1:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [2:0] resolve(input logic [REG_W-1:0] a,
                                         input logic [REG_W-1:0] b);
    logic [REG_W-1:0] c;
    c = a & b;
    if (c[B_ABL_100FD]) begin
      resolve = RES_100FD;
    end else if (c[B_ABL_100HD]) begin
      resolve = RES_100HD;
    end else if (c[B_ABL_10FD]) begin
      resolve = RES_10FD;
    end else if (c[B_ABL_10HD]) begin
      resolve = RES_10HD;
    end else begin
      resolve = RES_NONE;
    end
  endfunction

  function automatic logic [2:0] prog_code(input anarb_state_t s);
    case (s)
      ST_ABILITY: prog_code = PROG_ABILITY;
      ST_ACK: prog_code = PROG_ACK;
      default: prog_code = PROG_IDLE;
    endcase
  endfunction

  logic wr_fire;
  logic wr_ctrl;
  logic [REG_W-1:0] ctrl_val;
  logic sw_rst;
  logic restart_wr;
  logic rd_fire;
  logic rd_q;
  logic rd_exp;
  logic [REG_W-1:0] rd_word;
  logic en_eff;
  logic multi;
  logic any_rx;
  logic go_on;
  logic [2:0] res;
  logic [2:0] pres;
  logic tx_run;
  logic [REG_W-1:0] tx_word;

  // ***************************************
  // burst transmitter
  // ***************************************
  assign tx_run = (st_reg.fsm == ST_ABILITY) || (st_reg.fsm == ST_ACK);
  always_comb begin
    tx_word = st_reg.adv;
    tx_word[B_ABL_RFLT] = st_reg.adv[B_ABL_RFLT] | I_LOCAL_FAULT;
    tx_word[B_ABL_ACK] = st_reg.fsm == ST_ACK;
  end

  anarb_flp_tx #(
    .SLOT_CYC(FLP_SLOT_CYC_P),
    .BURST_CYC(FLP_BURST_CYC_P)
  ) u_flp_tx (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_run(tx_run),
    .i_word(tx_word),
    .o_pulse(O_TX_FLP)
  );

  // ***************************************
  // register read mux
  // ***************************************
  always_comb begin
    rd_word = '0;
    case (reg_idx(I_S_AXI_ARADDR))
      IDX_CTRL: rd_word[B_CTRL_EN] = st_reg.ctrl_en;
      IDX_STAT: begin
        rd_word[B_STAT_CMPL] = st_reg.cmpl;
        rd_word[B_STAT_RFLT] = st_reg.rfault;
        rd_word[B_STAT_ABLE] = 1'b1;
        rd_word[B_STAT_LINK] = st_reg.cmpl;
      end
      IDX_ADV: rd_word = st_reg.adv;
      IDX_LPA: rd_word = st_reg.lpa;
      IDX_EXP: begin
        rd_word[B_EXP_PDF] = st_reg.pd_fault;
        rd_word[B_EXP_LPCAP] = st_reg.lp_cap;
      end
      IDX_QSTAT: begin
        rd_word[B_Q_RATE] = st_reg.en100;
        rd_word[B_Q_DPX] = st_reg.fdx;
        rd_word[B_Q_PROG +: 3] = st_reg.prog;
        rd_word[B_Q_CMPL] = st_reg.cmpl;
        rd_word[B_Q_NOSIG] = st_reg.nosig;
        rd_word[B_Q_RFLT] = st_reg.rfault;
        rd_word[B_Q_LINK] = st_reg.cmpl;
      end
      IDX_XSTAT: rd_word[B_X_RFLT] = st_reg.rfault;
      default: rd_word = '0;
    endcase
  end

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    st_next = st_reg;
    // axi write channels, taken in either order
    if (I_S_AXI_AWVALID && st_reg.awready) begin
      st_next.awaddr = I_S_AXI_AWADDR;
      st_next.aw_full = 1'b1;
    end
    if (I_S_AXI_WVALID && st_reg.wready) begin
      st_next.wdata = I_S_AXI_WDATA[REG_W-1:0];
      st_next.wstrb = I_S_AXI_WSTRB[1:0];
      st_next.w_full = 1'b1;
    end
    if (st_reg.bvalid && I_S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end
    wr_fire = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    if (wr_fire) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = mapped(st_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.awready = !st_next.aw_full;
    st_next.wready = !st_next.w_full;
    wr_ctrl = wr_fire && (reg_idx(st_reg.awaddr) == IDX_CTRL);
    ctrl_val = '0;
    ctrl_val[B_CTRL_EN] = st_reg.ctrl_en;
    ctrl_val = merge16(ctrl_val, st_reg.wdata, st_reg.wstrb);
    sw_rst = wr_ctrl && ctrl_val[B_CTRL_SRST];
    restart_wr = wr_ctrl && ctrl_val[B_CTRL_RESTART];
    if (wr_ctrl) begin
      st_next.ctrl_en = ctrl_val[B_CTRL_EN];
    end
    if (wr_fire && (reg_idx(st_reg.awaddr) == IDX_ADV)) begin
      st_next.adv = merge16(st_reg.adv, st_reg.wdata, st_reg.wstrb);
    end
    // axi read channel
    if (st_reg.rvalid && I_S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    rd_fire = I_S_AXI_ARVALID && st_reg.arready;
    rd_q = rd_fire && (reg_idx(I_S_AXI_ARADDR) == IDX_QSTAT);
    rd_exp = rd_fire && (reg_idx(I_S_AXI_ARADDR) == IDX_EXP);
    if (rd_fire) begin
      st_next.rdata = {{(AXI_DW - REG_W){1'b0}}, rd_word};
      st_next.rresp = mapped(I_S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      st_next.rvalid = 1'b1;
      st_next.arready = 1'b0;
    end
    // address accepted whenever no read answer is pending
    st_next.arready = !st_next.rvalid;
    // negotiation
    en_eff = I_HW_MODE ? I_NEG_SELECT : st_reg.ctrl_en;
    any_rx = I_RX_FLP_VALID || I_RX_NLP || I_RX_IDLE100;
    multi = (I_RX_FLP_VALID && (I_RX_NLP || I_RX_IDLE100)) || (I_RX_NLP && I_RX_IDLE100);
    res = resolve(st_reg.adv, I_RX_FLP_WORD);
    if (rd_exp) begin
      st_next.pd_fault = 1'b0;
    end
    case (st_reg.fsm)
      ST_DISABLED: begin
        if (en_eff) begin
          st_next.fsm = ST_ABILITY;
        end
      end
      ST_ABILITY: begin
        if (multi) begin
          st_next.pd_fault = 1'b1;
        end else if (I_RX_FLP_VALID) begin
          st_next.lpa = I_RX_FLP_WORD;
          st_next.lp_cap = 1'b1;
          st_next.rfault = st_reg.rfault | I_RX_FLP_WORD[B_ABL_RFLT];
          st_next.fsm = ST_ACK;
        end else if (I_RX_NLP) begin
          st_next.lpa = '0;
          st_next.lpa[B_ABL_10HD] = 1'b1;
          st_next.lp_cap = 1'b0;
          st_next.en10 = 1'b1;
          st_next.fdx = 1'b0;
          st_next.cmpl = 1'b1;
          st_next.fsm = ST_COMPLETE;
        end else if (I_RX_IDLE100) begin
          st_next.lpa = '0;
          st_next.lpa[B_ABL_100HD] = 1'b1;
          st_next.lp_cap = 1'b0;
          st_next.en100 = 1'b1;
          st_next.fdx = 1'b0;
          st_next.cmpl = 1'b1;
          st_next.fsm = ST_COMPLETE;
        end
      end
      ST_ACK: begin
        if (I_RX_FLP_VALID) begin
          st_next.lpa = I_RX_FLP_WORD;
          st_next.rfault = st_reg.rfault | I_RX_FLP_WORD[B_ABL_RFLT];
          if (I_RX_FLP_WORD[B_ABL_ACK]) begin
            if (res != RES_NONE) begin
              {st_next.en100, st_next.en10, st_next.fdx} = res;
              st_next.cmpl = 1'b1;
              st_next.fsm = ST_COMPLETE;
            end else begin
              st_next.fsm = ST_ABILITY;
            end
          end
        end
      end
      ST_COMPLETE: st_next.fsm = ST_COMPLETE;
      default: st_next.fsm = ST_DISABLED;
    endcase
    // restart keeps the progress bits
    if (!en_eff || I_LINK_FAIL || restart_wr) begin
      st_next.fsm = ST_DISABLED;
      st_next.cmpl = 1'b0;
      st_next.en100 = 1'b0;
      st_next.en10 = 1'b0;
      st_next.fdx = 1'b0;
    end
    // no-signal watch
    if (any_rx) begin
      st_next.nosig_cnt = '0;
      st_next.nosig = 1'b0;
    end else if (st_reg.nosig_cnt == NOSIG_LIM) begin
      st_next.nosig = 1'b1;
    end else begin
      st_next.nosig_cnt = st_reg.nosig_cnt + 1'b1;
    end
    // progress monitor: keeps the highest, a read loads the present state
    pres = prog_code(st_reg.fsm);
    if (rd_q) begin
      st_next.prog = pres;
    end else if (!st_reg.cmpl && (pres > st_reg.prog)) begin
      st_next.prog = pres;
    end
    if (st_next.cmpl && !st_reg.cmpl) begin
      st_next.prog = PROG_DONE;
    end
    if (sw_rst) begin
      st_next.fsm = ST_DISABLED;
      st_next.prog = PROG_IDLE;
      st_next.cmpl = 1'b0;
      st_next.ctrl_en = CTRL_EN_RST;
      st_next.adv = ADV_RST;
      st_next.lpa = '0;
      st_next.lp_cap = 1'b0;
      st_next.pd_fault = 1'b0;
      st_next.rfault = 1'b0;
      st_next.en100 = 1'b0;
      st_next.en10 = 1'b0;
      st_next.fdx = 1'b0;
    end
    go_on = en_eff && !I_LINK_FAIL && !restart_wr && !sw_rst;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg <= '0;
      st_reg.fsm <= ST_DISABLED;
      st_reg.ctrl_en <= CTRL_EN_RST;
      st_reg.adv <= ADV_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  assign O_S_AXI_AWREADY = st_reg.awready;
  assign O_S_AXI_WREADY = st_reg.wready;
  assign O_S_AXI_BRESP = st_reg.bresp;
  assign O_S_AXI_BVALID = st_reg.bvalid;
  assign O_S_AXI_ARREADY = st_reg.arready;
  assign O_S_AXI_RDATA = st_reg.rdata;
  assign O_S_AXI_RRESP = st_reg.rresp;
  assign O_S_AXI_RVALID = st_reg.rvalid;
  assign O_EN_100TX = st_reg.en100;
  assign O_EN_10T = st_reg.en10;
  assign O_FULL_DUPLEX = st_reg.fdx;
  assign O_NEG_COMPLETE = st_reg.cmpl;

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_flp_store: assert property ((st_reg.fsm == ST_ABILITY) && I_RX_FLP_VALID && !multi && go_on
    |=> (st_reg.lpa == $past(I_RX_FLP_WORD)) && st_reg.lp_cap && (st_reg.fsm == ST_ACK))
    else $error("partner word not stored");
  a_nlp_parallel: assert property ((st_reg.fsm == ST_ABILITY) && I_RX_NLP && !multi && go_on
    |=> st_reg.cmpl && st_reg.en10 && !st_reg.en100 && st_reg.lpa[B_ABL_10HD] && !st_reg.lp_cap)
    else $error("link pulse parallel detect wrong");
  a_idle_parallel: assert property ((st_reg.fsm == ST_ABILITY) && I_RX_IDLE100 && !multi && go_on
    |=> st_reg.cmpl && st_reg.en100 && !st_reg.en10 && st_reg.lpa[B_ABL_100HD])
    else $error("idle parallel detect wrong");
  a_multi_fault: assert property ((st_reg.fsm == ST_ABILITY) && multi && !sw_rst
    |=> st_reg.pd_fault && !st_reg.cmpl)
    else $error("parallel fault not flagged");
  a_resolve_best: assert property ($rose(st_reg.cmpl) && st_reg.lp_cap
    && st_reg.adv[B_ABL_100FD] && st_reg.lpa[B_ABL_100FD] |-> st_reg.en100 && st_reg.fdx)
    else $error("best common technology not chosen");
  a_one_tech: assert property (st_reg.cmpl |-> (st_reg.en100 != st_reg.en10))
    else $error("not exactly one technology enabled");
  a_restart_idle: assert property (restart_wr || I_LINK_FAIL
    |=> (st_reg.fsm == ST_DISABLED) && !st_reg.cmpl && !st_reg.en100 && !st_reg.en10)
    else $error("restart did not return to idle");
  a_soft_reset: assert property (sw_rst |=> (st_reg.prog == PROG_IDLE) && !st_reg.pd_fault
    && (st_reg.fsm == ST_DISABLED))
    else $error("software reset left state");
  a_rfault_set: assert property (tx_run && I_RX_FLP_VALID && !multi && !sw_rst
    && I_RX_FLP_WORD[B_ABL_RFLT] |=> st_reg.rfault)
    else $error("remote fault not latched");
  a_nosig_quiet: assert property ($rose(st_reg.nosig) |-> $past(!any_rx, 1))
    else $error("no-signal set while receiving");
  a_done_code: assert property ($rose(st_reg.cmpl) |-> st_reg.prog == PROG_DONE)
    else $error("progress not complete code");

  c_negotiated: cover property ((st_reg.fsm == ST_ACK) ##1 (st_reg.fsm == ST_COMPLETE));
  c_parallel: cover property ($rose(st_reg.cmpl) && !st_reg.lp_cap);
  c_pd_fault: cover property ($rose(st_reg.pd_fault));
  c_status_read: cover property (rd_q && st_reg.cmpl);

endmodule

`default_nettype wire

//--- logic/anarb_pkg.sv
// constants and types of the negotiation arbiter
package anarb_pkg;

  // ***************************************
  // bus and register layout
  // ***************************************
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_STAT = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ADV = 6'h04;
  localparam logic [IDX_W-1:0] IDX_LPA = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EXP = 6'h06;
  localparam logic [IDX_W-1:0] IDX_QSTAT = 6'h11;
  localparam logic [IDX_W-1:0] IDX_XSTAT = 6'h13;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************
  // field positions and reset values
  // ***************************************
  localparam int B_CTRL_SRST = 15;
  localparam int B_CTRL_EN = 12;
  localparam int B_CTRL_RESTART = 9;
  localparam int B_STAT_CMPL = 5;
  localparam int B_STAT_RFLT = 4;
  localparam int B_STAT_ABLE = 3;
  localparam int B_STAT_LINK = 2;
  localparam int B_ABL_ACK = 14;
  localparam int B_ABL_RFLT = 13;
  localparam int B_ABL_100FD = 8;
  localparam int B_ABL_100HD = 7;
  localparam int B_ABL_10FD = 6;
  localparam int B_ABL_10HD = 5;
  localparam int B_EXP_PDF = 4;
  localparam int B_EXP_LPCAP = 0;
  localparam int B_Q_RATE = 15;
  localparam int B_Q_DPX = 14;
  localparam int B_Q_PROG = 11;
  localparam int B_Q_CMPL = 4;
  localparam int B_Q_NOSIG = 3;
  localparam int B_Q_RFLT = 1;
  localparam int B_Q_LINK = 0;
  localparam int B_X_RFLT = 13;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [REG_W-1:0] ADV_RST = 16'h01e1;

  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_NS = 4;
  localparam int FLP_SLOT_NS = 62500;
  localparam int FLP_BURST_NS = 16000000;
  localparam int FLP_PW_NS = 100;
  localparam int FLP_SLOT_CYC = FLP_SLOT_NS / CLK_NS;
  localparam int FLP_BURST_CYC = FLP_BURST_NS / CLK_NS;
  localparam int FLP_PW_CYC = (FLP_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLP_SLOTS = 33;
  localparam int NOSIG_BURSTS = 2;
  localparam int CNT_W = 24;
  localparam int SLOT_W = 6;

  // ***************************************
  // states, progress codes, resolution
  // ***************************************
  typedef enum logic [3:0] {
    ST_DISABLED = 4'h1,
    ST_ABILITY = 4'h2,
    ST_ACK = 4'h4,
    ST_COMPLETE = 4'h8
  } anarb_state_t;

  localparam logic [2:0] PROG_IDLE = 3'h0;
  localparam logic [2:0] PROG_ABILITY = 3'h1;
  localparam logic [2:0] PROG_ACK = 3'h3;
  localparam logic [2:0] PROG_DONE = 3'h7;

  // {enable 100, enable 10, full duplex}
  localparam logic [2:0] RES_NONE = 3'h0;
  localparam logic [2:0] RES_100FD = 3'h5;
  localparam logic [2:0] RES_100HD = 3'h4;
  localparam logic [2:0] RES_10FD = 3'h3;
  localparam logic [2:0] RES_10HD = 3'h2;

endpackage

//--- logic/anarb_flp_tx.sv
// fast link pulse burst generator
`timescale 1ns/1ps
`default_nettype none

module anarb_flp_tx #(
  parameter int SLOT_CYC = anarb_pkg::FLP_SLOT_CYC,
  parameter int BURST_CYC = anarb_pkg::FLP_BURST_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [anarb_pkg::REG_W-1:0] i_word,
  output logic o_pulse
);
  import anarb_pkg::*;

  localparam logic [CNT_W-1:0] SLOT_LIM = CNT_W'(SLOT_CYC - 1);
  localparam logic [CNT_W-1:0] BURST_LIM = CNT_W'(BURST_CYC - 1);
  localparam logic [CNT_W-1:0] PW_LIM = CNT_W'(FLP_PW_CYC);
  localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(FLP_SLOTS);

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [CNT_W-1:0] tick;
    logic [CNT_W-1:0] burst;
    logic [REG_W-1:0] word;
    logic pulse;
  } anarb_tx_st_t;

  anarb_tx_st_t st_reg;
  anarb_tx_st_t st_next;
  logic in_slot;
  logic data_one;

  // ***************************************
  // burst sequencing
  // ***************************************
  always_comb begin
    st_next = st_reg;
    in_slot = st_reg.slot < SLOT_END;
    // slot 32 is a clock slot, four index bits reach every data slot
    data_one = st_reg.word[st_reg.slot[SLOT_W-2:1]];
    if (!i_run) begin
      st_next.slot = '0;
      st_next.tick = '0;
      st_next.burst = '0;
      st_next.word = i_word;
      st_next.pulse = 1'b0;
    end else begin
      // even slots are clock pulses, odd slots carry one word bit
      st_next.pulse = in_slot && (st_reg.tick < PW_LIM) && (!st_reg.slot[0] || data_one);
      if (st_reg.burst == BURST_LIM) begin
        st_next.burst = '0;
        st_next.slot = '0;
        st_next.tick = '0;
        st_next.word = i_word;
      end else begin
        st_next.burst = st_reg.burst + 1'b1;
        if (in_slot) begin
          if (st_reg.tick == SLOT_LIM) begin
            st_next.tick = '0;
            st_next.slot = st_reg.slot + 1'b1;
          end else begin
            st_next.tick = st_reg.tick + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pulse = st_reg.pulse;

endmodule

`default_nettype wire

//--- test/anarb_partner.sv
// far-end link partner returning link code words
`timescale 1ns/1ps
`default_nettype none
module anarb_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_send,
  input wire logic [15:0] i_word,
  output logic o_valid,
  output logic [15:0] o_word
);
  // word exists only with its strobe, inverted every cycle otherwise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_word <= 16'h0000;
    end else begin
      o_valid <= i_send;
      o_word <= i_send ? i_word : ~o_word;
    end
  end
endmodule
`default_nettype wire

//--- test/anarb_top_tb.sv
// self-checking bench of the negotiation arbiter
`timescale 1ns/1ps
`default_nettype none
module anarb_top_tb;
  import anarb_pkg::*;
  logic clk, rst, awv, wv, bready, arv, rready, send, nlp, idle, lfail, lfault;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, tx_flp, en100, en10, fd, cmpl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [15:0] word, rx_word;
  logic [1:0] bresp, rresp;
  int fail_count, n_tests;
  anarb_top #(.FLP_SLOT_CYC_P(8), .FLP_BURST_CYC_P(400), .NOSIG_CYC_P(1000)) uut (
    .I_CLK(clk), .I_RST(rst), .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awv),
    .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(4'hf),
    .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp),
    .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr),
    .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata),
    .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready),
    .I_RX_FLP_VALID(rx_valid), .I_RX_FLP_WORD(rx_word), .I_RX_NLP(nlp),
    .I_RX_IDLE100(idle), .I_LINK_FAIL(lfail), .I_LOCAL_FAULT(lfault), .I_HW_MODE(1'b0),
    .I_NEG_SELECT(1'b1), .O_TX_FLP(tx_flp), .O_EN_100TX(en100), .O_EN_10T(en10),
    .O_FULL_DUPLEX(fd), .O_NEG_COMPLETE(cmpl));
  anarb_partner lp (.i_clk(clk), .i_rst(rst), .i_send(send), .i_word(word),
    .o_valid(rx_valid), .o_word(rx_word));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // each channel released at its own handshake
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic flp(input logic [15:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wcmpl;
    int n = 0;
    while (cmpl !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_rst;
    rd(8'h00, 32'h1000, RESP_OKAY);
    rd(8'h10, 32'h01e1, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(8'h08, 32'hffff, RESP_SLVERR);
  endtask
  task automatic t_neg;
    int n = 0;
    while (tx_flp !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(tx_flp, 1'b1);
    flp(16'h00a1);
    flp(16'h40a1);
    wcmpl;
    chk({en100, en10, fd, cmpl}, 4'b1001);
    rd(8'h04, 32'h002c, RESP_OKAY);
    rd(8'h44, 32'hb811, RESP_OKAY);
    rd(8'h18, 32'h0001, RESP_OKAY);
  endtask
  task automatic t_pd(input logic k, input logic [3:0] exp);
    wr(8'h00, 32'h1200, RESP_OKAY);
    @(posedge clk);
    nlp <= !k;
    idle <= k;
    @(posedge clk);
    nlp <= 1'b0;
    idle <= 1'b0;
    wcmpl;
    chk({en100, en10, fd, cmpl}, exp);
    rd(8'h18, 32'h0, RESP_OKAY);
  endtask
  task automatic t_fault;
    wr(8'h00, 32'h1200, RESP_OKAY);
    flp(16'h2021);
    rd(8'h14, 32'h2021, RESP_OKAY);
    rd(8'h04, 32'h0018, RESP_OKAY);
    rd(8'h4c, 32'h2000, RESP_OKAY);
  endtask
  // link fail restarts; slot 27 of the new burst carries advertised bit 13
  task automatic t_lfault(input logic f);
    @(posedge clk);
    lfault <= f;
    lfail <= 1'b1;
    @(posedge clk);
    lfail <= 1'b0;
    repeat (2) @(posedge clk);
    while (tx_flp !== 1'b1) @(posedge clk);
    chk({en100, en10, fd, cmpl}, 4'b0000);
    repeat (220) @(posedge clk);
    chk(tx_flp, f);
  endtask
  task automatic t_multi;
    @(posedge clk);
    nlp <= 1'b1;
    idle <= 1'b1;
    @(posedge clk);
    nlp <= 1'b0;
    idle <= 1'b0;
    rd(8'h18, 32'h0010, RESP_OKAY);
    rd(8'h18, 32'h0000, RESP_OKAY);
  endtask
  task automatic t_nosig;
    repeat (1000) @(posedge clk);
    rd(8'h44, 32'h380a, RESP_OKAY);
    rd(8'h44, 32'h180a, RESP_OKAY);
  endtask
  task automatic t_srst;
    wr(8'h00, 32'h8000, RESP_OKAY);
    rd(8'h44, 32'h0808, RESP_OKAY);
    rd(8'h4c, 32'h0000, RESP_OKAY);
    rd(8'h00, 32'h1000, RESP_OKAY);
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {rst, awv, wv, bready, arv, rready, send, nlp, idle, lfail, lfault} = 11'h400;
    {awaddr, araddr, wdata, word} = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_rst;
    t_neg;
    t_pd(1'b0, 4'b0101);
    t_pd(1'b1, 4'b1001);
    t_lfault(1'b1);
    t_lfault(1'b0);
    t_multi;
    t_fault;
    t_nosig;
    t_srst;
    stop_test;
  end
  // run is under two thousand cycles
  initial begin
    #40000;
    fail_count++;
    stop_test;
  end
endmodule
`default_nettype wire
